// ===== rtl/smao_pkg.sv
// package of constants and types for the switch monitor alert output
// assumes one core clock at 125 mhz and a serial link clocked by its own sclk
package smao_pkg;

  localparam int          FLAG_W_DEF        = 8;
  localparam int          SW_W_DEF          = 24;
  localparam int          CMD_W             = 8;
  localparam int          CMD_READ_BIT      = 7;
  localparam int          ADDR_W            = 7;
  localparam logic [6:0]  FLAG_REG_ADDR     = 7'h01;
  localparam int          FLAG_SSC_BIT      = 0;
  localparam int          FLAG_TW_BIT       = 1;
  localparam int          FLAG_OV_BIT       = 2;
  localparam int          BIT_CNT_W         = 6;
  localparam int          CNT_W             = 16;

  localparam int          CLK_PERIOD_NS     = 8;
  localparam int          ALERT_PULSE_TIME_NS = 2000;
  localparam int          ALERT_GAP_TIME_NS   = 2000;
  localparam int          ALERT_QUIET_TIME_NS = 1000;
  localparam int          ALERT_PULSE_CYC   = (ALERT_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ALERT_GAP_CYC     = (ALERT_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ALERT_QUIET_CYC   = (ALERT_QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic        SCHEME_STATIC     = 1'b0;
  localparam logic        SCHEME_DYNAMIC    = 1'b1;

  typedef struct packed {
    logic first_edge;
    logic read_hit;
  } smao_link_t;

  typedef enum logic [1:0] {
    ALR_OFF,
    ALR_PULSE,
    ALR_GAP,
    ALR_QUIET
  } smao_state_t;

endpackage

// ===== rtl/smao_link.sv
// link-side serial front end, clocked by the host serial clock
// assumes cs_n high outside frames and the snapshot held steady during a frame
`timescale 1ns/1ns
module smao_link #(
  parameter int FLAG_W = smao_pkg::FLAG_W_DEF
) (
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              mosi,
  input  wire logic [FLAG_W-1:0] snap,
  output logic                   miso_o,
  output logic                   miso_oe_n,
  output smao_pkg::smao_link_t   link
);
  import smao_pkg::*;

  generate
    if (FLAG_W < 1 || FLAG_W + CMD_W > 62) begin : g_bad_flag_w
      $error("flag width does not fit the bit counter");
    end
  endgenerate

  logic [BIT_CNT_W-1:0] bit_cnt_r, bit_cnt_nxt;
  logic [CMD_W-1:0]     cmd_r, cmd_nxt;
  smao_link_t           link_r, link_nxt;
  logic                 miso_r, miso_nxt;
  logic                 oe_n_r;
  logic [BIT_CNT_W-1:0] idx;

  // shift command, flag first edge and decoded read
  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    if (bit_cnt_r != {BIT_CNT_W{1'b1}}) begin
      bit_cnt_nxt = bit_cnt_r + 1'b1;
    end
    cmd_nxt = cmd_r;
    if (bit_cnt_r < BIT_CNT_W'(CMD_W)) begin
      cmd_nxt = {cmd_r[CMD_W-2:0], mosi};
    end
    link_nxt = link_r;
    link_nxt.first_edge = 1'b1;
    if (bit_cnt_r == BIT_CNT_W'(CMD_W - 1)) begin
      link_nxt.read_hit = cmd_nxt[CMD_READ_BIT] && (cmd_nxt[ADDR_W-1:0] == FLAG_REG_ADDR);
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_r <= '0;
      cmd_r     <= '0;
      link_r    <= '0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      cmd_r     <= cmd_nxt;
      link_r    <= link_nxt;
    end
  end

  // data phase sends the captured flags, msb first
  always_comb begin
    idx      = bit_cnt_r - BIT_CNT_W'(CMD_W);
    miso_nxt = 1'b0;
    if (bit_cnt_r >= BIT_CNT_W'(CMD_W) && idx < BIT_CNT_W'(FLAG_W)) begin
      miso_nxt = snap[FLAG_W - 1 - int'(idx)];
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      miso_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      miso_r <= miso_nxt;
      oe_n_r <= 1'b0;
    end
  end

  assign miso_o    = miso_r;
  assign miso_oe_n = oe_n_r;
  assign link      = link_r;

endmodule

// ===== rtl/smao_alert.sv
// top of the alert output block: event flags, snapshot, alert sequencer
// assumes event and config inputs are on clk; sclk and cs_n come from the host
`timescale 1ns/1ns
module smao_alert #(
  parameter int FLAG_W    = smao_pkg::FLAG_W_DEF,
  parameter int SW_W      = smao_pkg::SW_W_DEF,
  parameter int PULSE_CYC = smao_pkg::ALERT_PULSE_CYC,
  parameter int GAP_CYC   = smao_pkg::ALERT_GAP_CYC,
  parameter int QUIET_CYC = smao_pkg::ALERT_QUIET_CYC
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              mosi,
  output logic                   miso_o,
  output logic                   miso_oe_n,
  input  wire logic              run_en,
  input  wire logic              scheme_sel,
  input  wire logic [SW_W-1:0]   sw_int_en,
  input  wire logic [FLAG_W-1:0] event_mask,
  input  wire logic [SW_W-1:0]   switch_change_event,
  input  wire logic              temp_warn_event,
  input  wire logic              over_volt_event,
  output logic                   alert_o,
  output logic                   alert_oe_n,
  output logic [FLAG_W-1:0]      flag_status,
  output logic                   quiet_active
);
  import smao_pkg::*;

  generate
    if (FLAG_W < 3 || FLAG_W > 32) begin : g_bad_flag_w
      $error("flag width out of range");
    end
    if (SW_W < 1) begin : g_bad_sw_w
      $error("switch count must be positive");
    end
    if (PULSE_CYC < 1 || GAP_CYC < 1 || QUIET_CYC < 1) begin : g_bad_time
      $error("alert times must be at least one cycle");
    end
    if (PULSE_CYC >= 2**CNT_W || GAP_CYC >= 2**CNT_W || QUIET_CYC >= 2**CNT_W) begin : g_big_time
      $error("alert time exceeds counter");
    end
  endgenerate

  localparam logic [CNT_W-1:0] PULSE_LD = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] GAP_LD   = CNT_W'(GAP_CYC - 1);
  localparam logic [CNT_W-1:0] QUIET_LD = CNT_W'(QUIET_CYC - 1);

  // link-side front end
  smao_link_t        link;
  logic [FLAG_W-1:0] snap_r, snap_nxt;
  logic              miso_w;
  logic              miso_oe_n_w;

  smao_link #(
    .FLAG_W    (FLAG_W)
  ) u_link (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .mosi      (mosi),
    .snap      (snap_r),
    .miso_o    (miso_w),
    .miso_oe_n (miso_oe_n_w),
    .link      (link)
  );

  assign miso_o    = miso_w;
  assign miso_oe_n = miso_oe_n_w;

  // two-stage synchronisers for cs_n, first edge and read hit
  logic [2:0] sync1_r, sync2_r, prev_r;
  logic       cs_s, first_s, hit_s;
  logic       cs_rise, first_rise;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_r <= 3'b001;
      sync2_r <= 3'b001;
      prev_r  <= 3'b001;
    end else begin
      sync1_r <= {link.read_hit, link.first_edge, cs_n};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign cs_s       = sync2_r[0];
  assign first_s    = sync2_r[1];
  assign hit_s      = sync2_r[2];
  assign cs_rise    = cs_s && !prev_r[0];
  assign first_rise = first_s && !prev_r[1];

  // read seen in the current frame, acted on at frame end
  logic read_seen_r, read_seen_nxt;
  logic read_end;

  always_comb begin
    read_seen_nxt = read_seen_r;
    if (cs_rise) begin
      read_seen_nxt = 1'b0;
    end else if (hit_s) begin
      read_seen_nxt = 1'b1;
    end
  end

  assign read_end = cs_rise && (read_seen_r || hit_s);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      read_seen_r <= 1'b0;
    end else begin
      read_seen_r <= read_seen_nxt;
    end
  end

  // scheme and switch enables held while running; event_mask used live
  logic            scheme_r, scheme_nxt;
  logic [SW_W-1:0] sw_en_r, sw_en_nxt;

  always_comb begin
    scheme_nxt = scheme_r;
    sw_en_nxt  = sw_en_r;
    if (!run_en) begin
      scheme_nxt = scheme_sel;
      sw_en_nxt  = sw_int_en;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      scheme_r <= SCHEME_STATIC;
      sw_en_r  <= '0;
    end else begin
      scheme_r <= scheme_nxt;
      sw_en_r  <= sw_en_nxt;
    end
  end

  // event flags: new events win over a clear in the same cycle
  logic [FLAG_W-1:0] flags_r, flags_nxt;
  logic [FLAG_W-1:0] ev_set;
  logic [FLAG_W-1:0] ev_clr;
  logic              pending;

  always_comb begin
    ev_set = '0;
    ev_set[FLAG_SSC_BIT] = |(switch_change_event & sw_en_r);
    ev_set[FLAG_TW_BIT]  = temp_warn_event;
    ev_set[FLAG_OV_BIT]  = over_volt_event;
    ev_clr = '0;
    if (read_end) begin
      ev_clr = snap_r;
    end
    flags_nxt = (flags_r & ~ev_clr) | ev_set;
  end

  assign pending = |(flags_r & ~event_mask);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // snapshot taken at the first sclk edge of every frame
  always_comb begin
    snap_nxt = snap_r;
    if (first_rise) begin
      snap_nxt = flags_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      snap_r <= '0;
    end else begin
      snap_r <= snap_nxt;
    end
  end

  // alert sequencer
  smao_state_t      state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             cnt_done;

  assign cnt_done = (cnt_r == '0);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (!cnt_done) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    case (state_r)
      ALR_OFF: begin
        if (pending) begin
          state_nxt = ALR_PULSE;
          cnt_nxt   = PULSE_LD;
        end
      end
      ALR_PULSE: begin
        if (read_end) begin
          state_nxt = ALR_QUIET;
          cnt_nxt   = QUIET_LD;
        end else if (scheme_r == SCHEME_DYNAMIC && cnt_done) begin
          state_nxt = ALR_GAP;
          cnt_nxt   = GAP_LD;
        end
      end
      ALR_GAP: begin
        if (read_end) begin
          state_nxt = ALR_QUIET;
          cnt_nxt   = QUIET_LD;
        end else if (cnt_done) begin
          state_nxt = pending ? ALR_PULSE : ALR_OFF;
          cnt_nxt   = PULSE_LD;
        end
      end
      ALR_QUIET: begin
        if (cnt_done) begin
          state_nxt = pending ? ALR_PULSE : ALR_OFF;
          cnt_nxt   = PULSE_LD;
        end
      end
      default: begin
        state_nxt = ALR_OFF;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= ALR_OFF;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // registered pin enable and status outputs; alert data pin tied low
  logic              oe_n_r, oe_n_nxt;
  logic              quiet_r, quiet_nxt;
  logic [FLAG_W-1:0] stat_r;

  always_comb begin
    oe_n_nxt  = (state_nxt != ALR_PULSE);
    quiet_nxt = (state_nxt == ALR_QUIET);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      oe_n_r  <= 1'b1;
      quiet_r <= 1'b0;
      stat_r  <= '0;
    end else begin
      oe_n_r  <= oe_n_nxt;
      quiet_r <= quiet_nxt;
      stat_r  <= flags_nxt;
    end
  end

  assign alert_o      = 1'b0;
  assign alert_oe_n   = oe_n_r;
  assign quiet_active = quiet_r;
  assign flag_status  = stat_r;

endmodule

// ===== dv/smao_monitor.sv
// checker for the alert output block, bound to its top
// assumes scheme and enables change only while run control is low
`timescale 1ns/1ns
module smao_monitor #(
  parameter int FLAG_W    = 8,
  parameter int SW_W      = 24,
  parameter int PULSE_CYC = 4,
  parameter int GAP_CYC   = 4,
  parameter int QUIET_CYC = 4
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              sclk,
  input wire logic              cs_n,
  input wire logic              mosi,
  input wire logic              miso_o,
  input wire logic              miso_oe_n,
  input wire logic              run_en,
  input wire logic              scheme_sel,
  input wire logic [SW_W-1:0]   sw_int_en,
  input wire logic [FLAG_W-1:0] event_mask,
  input wire logic [SW_W-1:0]   switch_change_event,
  input wire logic              temp_warn_event,
  input wire logic              over_volt_event,
  input wire logic              alert_o,
  input wire logic              alert_oe_n,
  input wire logic [FLAG_W-1:0] flag_status,
  input wire logic              quiet_active
);
  import smao_pkg::*;
  logic        scheme_r;
  logic [15:0] low_r;
  logic [15:0] qcnt_r;
  // scheme copy, low run length, quiet length
  always_ff @(posedge clk) begin
    scheme_r <= !nrst ? 1'b0 : (run_en ? scheme_r : scheme_sel);
    low_r    <= (!nrst || alert_oe_n) ? '0 : low_r + 16'h0001;
    qcnt_r   <= (!nrst || !quiet_active) ? '0 : qcnt_r + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_alert_data: assert property (alert_o == 1'b0)
    else $error("alert data level not low");
  a_event_alert: assert property (temp_warn_event && !event_mask[FLAG_TW_BIT] && alert_oe_n
    && !quiet_active && flag_status == '0 |-> ##2 !alert_oe_n) else $error("event did not pull alert");
  a_flag_set: assert property (over_volt_event |-> ##1 flag_status[FLAG_OV_BIT])
    else $error("flag not set after event");
  a_quiet_gate: assert property (quiet_active |-> alert_oe_n)
    else $error("alert low during quiet");
  a_static_hold: assert property (!scheme_r && $rose(alert_oe_n) |-> quiet_active)
    else $error("static alert released without read");
  a_pulse_max: assert property (scheme_r && !alert_oe_n |-> low_r < PULSE_CYC)
    else $error("dynamic pulse too long");
  a_gap_min: assert property (scheme_r && $rose(alert_oe_n) && !quiet_active |=> alert_oe_n [*3])
    else $error("dynamic gap too short");
  a_quiet_len: assert property ($fell(quiet_active) |-> qcnt_r == QUIET_CYC)
    else $error("quiet length wrong");
  a_quiet_max: assert property (qcnt_r <= QUIET_CYC)
    else $error("quiet overran");
  c_pulse: cover property (scheme_r && $fell(alert_oe_n));
  c_quiet: cover property ($rose(quiet_active));
  c_quiet_ev: cover property (quiet_active && over_volt_event);
endmodule
bind smao_alert smao_monitor #(.FLAG_W(FLAG_W), .SW_W(SW_W), .PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC),
  .QUIET_CYC(QUIET_CYC)) u_smao_monitor (.*);

// ===== dv/smao_host.sv
// serial host model reading the flag register
// assumes sclk idles low outside frames, 125 ns period inside
`timescale 1ns/1ns
module smao_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso_o,
  output logic      host_regulator_hold
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    host_regulator_hold = 1'b0;
  end
  // one frame: command byte out, flag byte in
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] dat);
    host_regulator_hold = 1'b1;
    cs_n = 1'b0;
    #37;
    for (int i = 15; i >= 0; i--) begin
      mosi = (i > 7) ? cmd[i-8] : ~mosi;
      #62 sclk = 1'b1;
      if (i < 8) dat[i] = miso_o;
      #63 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// ===== dv/smao_alert_tb.sv
// testbench for the alert output block
// assumes the host model drives the link; short pulse and gap counts, quiet count of 400 cycles
`timescale 1ns/1ns
module smao_alert_tb;
  import smao_pkg::*;
  typedef struct packed {
    logic [2:0] ev;
    logic [7:0] mask;
    logic [7:0] flags;
    logic       alert_n;
  } smao_row_t;
  localparam int QC = 400;
  logic        clk, nrst, sclk, cs_n, mosi, miso_o, miso_oe_n, run_en, scheme_sel;
  logic        temp_warn_event, over_volt_event, alert_o, alert_oe_n, quiet_active;
  logic        host_regulator_hold, p;
  logic [23:0] sw_int_en, switch_change_event;
  logic [7:0]  event_mask, flag_status, d;
  int          fails, compares, t;
  smao_row_t   rows [4] = '{'{3'h2, 8'h00, 8'h02, 1'h0}, '{3'h4, 8'h00, 8'h04, 1'h0},
                            '{3'h1, 8'h00, 8'h01, 1'h0}, '{3'h2, 8'h02, 8'h02, 1'h1}};
  smao_alert #(.PULSE_CYC(4), .GAP_CYC(4), .QUIET_CYC(QC)) u_smao_alert (.*);
  smao_host u_smao_host (.*);
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ev(logic [2:0] e);
    @(negedge clk);
    switch_change_event[5] = e[0];
    temp_warn_event = e[1];
    over_volt_event = e[2];
    @(negedge clk);
    switch_change_event = '0;
    temp_warn_event = 1'b0;
    over_volt_event = 1'b0;
  endtask
  task automatic rd(logic [7:0] cmd, logic [7:0] e);
    u_smao_host.xfer(cmd, d);
    chk("miso data", e, d);
    cyc(8);
    chk("miso idle", 8'h01, miso_oe_n);
  endtask
  task automatic wq();
    int n;
    n = 0;
    while (quiet_active === 1'b1 && n < 1000) begin
      n++;
      @(negedge clk);
    end
    if (n == 1000) begin
      fails++;
      close_out();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    fails = 0;
    compares = 0;
    nrst = 1'b0;
    run_en = 1'b0;
    scheme_sel = 1'b0;
    sw_int_en = '1;
    event_mask = '0;
    switch_change_event = '0;
    temp_warn_event = 1'b0;
    over_volt_event = 1'b0;
    cyc(6);
    nrst = 1'b1;
    cyc(4);
    run_en = 1'b1;
    foreach (rows[i]) begin
      event_mask = rows[i].mask;
      ev(rows[i].ev);
      cyc(2);
      chk("flags", rows[i].flags, flag_status);
      chk("alert", rows[i].alert_n, alert_oe_n);
      rd(8'h81, rows[i].flags);
      chk("cleared", 8'h00, flag_status);
      chk("released", 1'h1, alert_oe_n);
      wq();
    end
    event_mask = '0;
    run_en = 1'b0;
    scheme_sel = 1'b1;
    cyc(2);
    run_en = 1'b1;
    ev(3'h2);
    t = 0;
    repeat (40) begin
      p = alert_oe_n;
      @(negedge clk);
      t += (p !== alert_oe_n);
    end
    chk("toggling", 1'h1, t >= 8);
    rd(8'h81, 8'h02);
    chk("dyn cleared", 8'h00, flag_status);
    wq();
    cyc(20);
    chk("dyn quiet", 1'h1, alert_oe_n);
    run_en = 1'b0;
    scheme_sel = 1'b0;
    cyc(2);
    run_en = 1'b1;
    ev(3'h2);
    rd(8'h01, 8'h02);
    rd(8'h82, 8'h02);
    chk("kept", 8'h02, flag_status);
    fork
      rd(8'h81, 8'h02);
      begin
        cyc(60);
        chk("miso drive", 8'h00, miso_oe_n);
        ev(3'h4);
      end
    join
    chk("late flag", 8'h04, flag_status);
    chk("quiet", 1'h1, quiet_active);
    chk("held off", 1'h1, alert_oe_n);
    rd(8'h81, 8'h04);
    chk("quiet clear", 8'h00, flag_status);
    wq();
    cyc(4);
    chk("no alert", 1'h1, alert_oe_n);
    ev(3'h2);
    rd(8'h81, 8'h02);
    ev(3'h4);
    wq();
    cyc(3);
    chk("after quiet", 1'h0, alert_oe_n);
    rd(8'h81, 8'h04);
    wq();
    run_en = 1'b0;
    scheme_sel = 1'b1;
    cyc(2);
    run_en = 1'b1;
    nrst = 1'b0;
    cyc(6);
    nrst = 1'b1;
    cyc(4);
    chk("rst flags", 8'h00, flag_status);
    chk("rst alert", 1'h1, alert_oe_n);
    ev(3'h1);
    cyc(3);
    chk("sw off", 8'h00, flag_status);
    ev(3'h2);
    t = 0;
    repeat (30) begin
      p = alert_oe_n;
      @(negedge clk);
      t += (p !== alert_oe_n);
    end
    chk("static", 1'h0, alert_oe_n);
    chk("static steady", 8'h01, t[7:0]);
    chk("alert data", 8'h00, alert_o);
    close_out();
  end
endmodule
